// *** rtl/radio_irq_pkg.sv ***
// Package with register map, field layout, reset values and mode codes of the flag unit.
package radio_irq_pkg;

    // ==========================================================================
    // Register offsets.
    localparam logic [7:0] ADDR_PIN_ROUTE_LOW   = 8'h25;
    localparam logic [7:0] ADDR_PIN_ROUTE_HIGH  = 8'h26;
    localparam logic [7:0] ADDR_FLAGS_MODE      = 8'h27;
    localparam logic [7:0] ADDR_FLAGS_BUFFER    = 8'h28;
    localparam logic [7:0] ADDR_STRENGTH_THRESH = 8'h29;
    localparam logic [7:0] ADDR_RX_START_TO     = 8'h2a;
    localparam logic [7:0] ADDR_POST_STRENGTH_TO = 8'h2b;

    // ==========================================================================
    // Field positions in the mode flag register.
    localparam int BIT_MODE_REACHED = 7;
    localparam int BIT_RX_SETTLED   = 6;
    localparam int BIT_TX_SETTLED   = 5;
    localparam int BIT_SYNTH_LOCKED = 4;
    localparam int BIT_STRENGTH     = 3;
    localparam int BIT_TIMEOUT      = 2;
    localparam int BIT_AUTO_SEQ     = 1;
    localparam int BIT_SYNC_MATCH   = 0;

    // Field positions in the buffer flag register.
    localparam int BIT_BUF_FULL     = 7;
    localparam int BIT_BUF_NONEMPTY = 6;
    localparam int BIT_BUF_LEVEL    = 5;
    localparam int BIT_BUF_OVERFLOW = 4;
    localparam int BIT_FRAME_SENT   = 3;
    localparam int BIT_RX_COMPLETE  = 2;
    localparam int BIT_CHECKSUM_OK  = 1;

    // ==========================================================================
    // Reset values.
    localparam logic [1:0] RST_ROUTE_SEL   = 2'h0;
    localparam logic [2:0] RST_CLK_SEL     = 3'h7;
    localparam logic [7:0] RST_THRESHOLD   = 8'he4;
    localparam logic [7:0] RST_TIMEOUT     = 8'h00;
    localparam logic       RST_MODE_REACHED = 1'b1;

    // ==========================================================================
    // Clock output select codes and timing.
    localparam logic [2:0] CLK_SEL_RC  = 3'h6;
    localparam logic [2:0] CLK_SEL_OFF = 3'h7;
    localparam int         TIMEOUT_BITS_PER_UNIT = 16;
    localparam int         BUFFER_DEPTH = 66;

    // Operating mode codes seen on the mode input.
    localparam logic [2:0] MODE_SLEEP   = 3'h0;
    localparam logic [2:0] MODE_STANDBY = 3'h1;
    localparam logic [2:0] MODE_SYNTH   = 3'h2;
    localparam logic [2:0] MODE_TX      = 3'h3;
    localparam logic [2:0] MODE_RX      = 3'h4;

    // Event chosen by a pin route select code.
    localparam logic [1:0] ROUTE_LEVEL    = 2'h0;
    localparam logic [1:0] ROUTE_NONEMPTY = 2'h1;
    localparam logic [1:0] ROUTE_SYNC     = 2'h2;
    localparam logic [1:0] ROUTE_READY    = 2'h3;

endpackage : radio_irq_pkg

// *** rtl/radio_irq_flags_pin_map.sv ***
// Event flag registers, pin routing, clock output divider and receive timeouts.
// Notes on behaviour
// - Six 2-bit pin route selects, reset 00.
// - Clock pin select: divide 1..32, RC, off.
// - Mode reached bit7, cleared on mode change.
// - Receive settled bit6, cleared leaving receive.
// - Transmit settled bit5, cleared leaving transmit.
// - Synth locked bit4 follows lock in synth/rx/tx.
// - Strength bit3, host write clears, rx only.
// - Timeout bit2 on expiry, cleared rx exit/empty.
// - Auto sequence bit1 follows intermediate mode.
// - Sync match bit0; write-clear in continuous only.
// - Buffer full exactly at 66 bytes.
// - Buffer nonempty when one byte or more.
// - Buffer level when count exceeds threshold.
// - Overflow set outside sleep; write 1 flushes.
// - Frame transmitted bit3, cleared leaving transmit.
// - Receive complete bit2 after last byte, CRC rules.
// - Checksum good bit1, cleared when buffer empties.
// - Strength threshold register, reset e4, compared.
// - Start timeout: value*16 bits without strength.
// - Post-strength timeout: value*16 bits without frame.
// - Bad CRC: flush and restart unless kept.
`timescale 1ns/1ps
module radio_irq_flags_pin_map
    import radio_irq_pkg::*;
#(
    parameter int DEPTH_W = 7
) (
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire logic [7:0]         addr,
    input  wire logic [7:0]         wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic      [7:0]         rdata,
    input  wire logic [2:0]         mode,
    input  wire logic               mode_done,
    input  wire logic               rx_settled,
    input  wire logic               tx_ramped,
    input  wire logic               synth_lock,
    input  wire logic               strength_valid,
    input  wire logic [7:0]         measured_strength,
    input  wire logic               intermediate_mode,
    input  wire logic               sync_found,
    input  wire logic               continuous_mode,
    input  wire logic [DEPTH_W-1:0] buffer_count,
    input  wire logic [DEPTH_W-1:0] buffer_level_threshold,
    input  wire logic               buffer_overrun,
    input  wire logic               frame_done,
    input  wire logic               last_byte,
    input  wire logic               crc_on,
    input  wire logic               crc_pass,
    input  wire logic               keep_bad_frame,
    input  wire logic               bit_tick,
    input  wire logic               rc_clock,
    output logic [5:0]              pins,
    output logic                    clock_pin,
    output logic                    rc_enable,
    output logic                    buffer_flush,
    output logic                    rx_restart
);

    // ==========================================================================
    // Reset release through two flip-flops.
    logic rst_meta;
    logic rst_n_sync;

    // Both stages take a constant under reset and shift a one after release.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta   <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_n_sync <= rst_meta;
        end
    end

    // ==========================================================================
    // State of the block.
    typedef struct packed {
        logic [5:0][1:0] route;
        logic [2:0]      clk_sel;
        logic [7:0]      thresh;
        logic [7:0]      to_start;
        logic [7:0]      to_post;
        logic [2:0]      mode_prev;
        logic [7:0]      flags_mode;
        logic [7:0]      flags_buf;
        logic            nonempty_prev;
        logic            t1_run;
        logic [11:0]     t1_cnt;
        logic            t2_run;
        logic [11:0]     t2_cnt;
        logic [4:0]      div_cnt;
        logic            div_out;
        logic [5:0]      pins;
        logic [7:0]      rdata;
        logic            flush;
        logic            restart;
    } state_s;

    state_s st_reg;
    state_s st_next;

    // Pick the routed event of one pin from the flag registers.
    function automatic logic route_event(input logic [1:0] sel, input logic [7:0] fm,
                                         input logic [7:0] fb);
        case (sel)
            ROUTE_LEVEL:    route_event = fb[BIT_BUF_LEVEL];
            ROUTE_NONEMPTY: route_event = fb[BIT_BUF_NONEMPTY];
            ROUTE_SYNC:     route_event = fm[BIT_SYNC_MATCH];
            default:        route_event = fm[BIT_MODE_REACHED];
        endcase
    endfunction : route_event

    // Timeout limit in ticks: value times sixteen bit periods.
    function automatic logic [11:0] to_limit(input logic [7:0] v);
        to_limit = 12'(v) * 12'(TIMEOUT_BITS_PER_UNIT);
    endfunction : to_limit

    // Decoded events of this cycle.
    logic in_rx;
    logic in_tx;
    logic mode_changed;
    logic emptied;
    logic wr_flags_mode;
    logic wr_flags_buf;
    logic strength_hit;
    logic frame_ok;
    logic frame_bad;
    logic t1_fire;
    logic t2_fire;
    logic ovf_clear;

    // Conditions shared by several flags.
    always_comb begin
        in_rx         = (mode == MODE_RX);
        in_tx         = (mode == MODE_TX);
        mode_changed  = (mode != st_reg.mode_prev);
        emptied       = st_reg.nonempty_prev && (buffer_count == '0);
        wr_flags_mode = wr && (addr == ADDR_FLAGS_MODE);
        wr_flags_buf  = wr && (addr == ADDR_FLAGS_BUFFER);
        ovf_clear     = wr_flags_buf && wdata[BIT_BUF_OVERFLOW];
        strength_hit  = in_rx && strength_valid
                        && (measured_strength > st_reg.thresh);
        frame_ok      = in_rx && last_byte && (!crc_on || crc_pass || keep_bad_frame);
        frame_bad     = in_rx && last_byte && crc_on && !crc_pass && !keep_bad_frame;
        t1_fire       = in_rx && st_reg.t1_run && bit_tick
                        && (st_reg.t1_cnt + 12'h001 == to_limit(st_reg.to_start));
        t2_fire       = in_rx && st_reg.t2_run && bit_tick
                        && (st_reg.t2_cnt + 12'h001 == to_limit(st_reg.to_post));
    end

    // ==========================================================================
    // Next-state logic for registers, flags, timers, divider and pins.
    always_comb begin
        st_next           = st_reg;
        st_next.mode_prev = mode;

        // Host writes to configuration registers.
        if (wr) begin
            case (addr)
                ADDR_PIN_ROUTE_LOW: begin
                    st_next.route[0] = wdata[7:6];
                    st_next.route[1] = wdata[5:4];
                    st_next.route[2] = wdata[3:2];
                    st_next.route[3] = wdata[1:0];
                end
                ADDR_PIN_ROUTE_HIGH: begin
                    st_next.route[4] = wdata[7:6];
                    st_next.route[5] = wdata[5:4];
                    st_next.clk_sel  = wdata[2:0];
                end
                ADDR_STRENGTH_THRESH:  st_next.thresh   = wdata;
                ADDR_RX_START_TO:      st_next.to_start = wdata;
                ADDR_POST_STRENGTH_TO: st_next.to_post  = wdata;
                default: ;
            endcase
        end

        // Mode flags: clears first, then sets so that a set wins.
        if (mode_changed) begin
            st_next.flags_mode[BIT_MODE_REACHED] = 1'b0;
        end
        if (mode_done) begin
            st_next.flags_mode[BIT_MODE_REACHED] = 1'b1;
        end
        st_next.flags_mode[BIT_RX_SETTLED] = in_rx
            && (st_reg.flags_mode[BIT_RX_SETTLED] || rx_settled);
        st_next.flags_mode[BIT_TX_SETTLED] = in_tx
            && (st_reg.flags_mode[BIT_TX_SETTLED] || tx_ramped);
        st_next.flags_mode[BIT_SYNTH_LOCKED] = synth_lock
            && (mode == MODE_SYNTH || in_rx || in_tx);
        st_next.flags_mode[BIT_STRENGTH] = in_rx && (strength_hit
            || (st_reg.flags_mode[BIT_STRENGTH]
                && !(wr_flags_mode && wdata[BIT_STRENGTH])));
        st_next.flags_mode[BIT_TIMEOUT] = in_rx && (t1_fire || t2_fire
            || (st_reg.flags_mode[BIT_TIMEOUT] && !emptied && !ovf_clear));
        st_next.flags_mode[BIT_AUTO_SEQ] = intermediate_mode;
        st_next.flags_mode[BIT_SYNC_MATCH] = in_rx && (sync_found
            || (st_reg.flags_mode[BIT_SYNC_MATCH] && !emptied && !ovf_clear
                && !(continuous_mode && wr_flags_mode && wdata[BIT_SYNC_MATCH])));

        // Buffer flags; full, nonempty and level follow the live byte count.
        st_next.flags_buf[BIT_BUF_FULL] =
            (buffer_count == DEPTH_W'(BUFFER_DEPTH));
        st_next.flags_buf[BIT_BUF_NONEMPTY] = (buffer_count != '0);
        st_next.flags_buf[BIT_BUF_LEVEL] =
            (buffer_count > buffer_level_threshold);
        st_next.flags_buf[BIT_BUF_OVERFLOW] = (buffer_overrun && mode != MODE_SLEEP)
            || (st_reg.flags_buf[BIT_BUF_OVERFLOW] && !ovf_clear);
        st_next.flags_buf[BIT_FRAME_SENT] = in_tx
            && (frame_done || st_reg.flags_buf[BIT_FRAME_SENT]);
        st_next.flags_buf[BIT_RX_COMPLETE] = frame_ok || (st_reg.flags_buf[BIT_RX_COMPLETE]
            && !emptied && !ovf_clear && !frame_bad);
        st_next.flags_buf[BIT_CHECKSUM_OK] = (in_rx && last_byte && crc_pass)
            || (st_reg.flags_buf[BIT_CHECKSUM_OK] && !emptied && !ovf_clear);
        st_next.flags_buf[0] = 1'b0;
        st_next.nonempty_prev = (buffer_count != '0);

        // Overflow clear or a rejected frame empties the buffer.
        st_next.flush   = ovf_clear || frame_bad;
        st_next.restart = frame_bad;

        // Start timer runs from receive entry until a strength event.
        if (!in_rx || strength_hit || t1_fire) begin
            st_next.t1_run = 1'b0;
        end else if (mode_changed && st_reg.to_start != RST_TIMEOUT) begin
            st_next.t1_run = 1'b1;
            st_next.t1_cnt = '0;
        end else if (st_reg.t1_run && bit_tick) begin
            st_next.t1_cnt = st_reg.t1_cnt + 12'h001;
        end

        // Post-strength timer runs from a strength event until a complete frame.
        if (!in_rx || frame_ok || t2_fire) begin
            st_next.t2_run = 1'b0;
        end else if (strength_hit && st_reg.to_post != RST_TIMEOUT) begin
            st_next.t2_run = 1'b1;
            st_next.t2_cnt = '0;
        end else if (st_reg.t2_run && bit_tick) begin
            st_next.t2_cnt = st_reg.t2_cnt + 12'h001;
        end

        // Free-running divider; bit n-1 toggles at reference over two to the n.
        st_next.div_cnt = st_reg.div_cnt + 5'h01;
        if (st_reg.clk_sel >= 3'h1 && st_reg.clk_sel <= 3'h5) begin
            st_next.div_out = st_next.div_cnt[st_reg.clk_sel - 3'h1];
        end else begin
            st_next.div_out = 1'b0;
        end

        // Pins follow the next flag values so register and pin agree.
        for (int i = 0; i < 6; i++) begin
            st_next.pins[i] = route_event(st_next.route[i], st_next.flags_mode,
                                          st_next.flags_buf);
        end

        // Read data is captured for the cycle after the read strobe.
        if (rd) begin
            case (addr)
                ADDR_PIN_ROUTE_LOW:    st_next.rdata = {st_reg.route[0], st_reg.route[1],
                                                        st_reg.route[2], st_reg.route[3]};
                ADDR_PIN_ROUTE_HIGH:   st_next.rdata = {st_reg.route[4], st_reg.route[5],
                                                        1'b0, st_reg.clk_sel};
                ADDR_FLAGS_MODE:       st_next.rdata = st_reg.flags_mode;
                ADDR_FLAGS_BUFFER:     st_next.rdata = st_reg.flags_buf;
                ADDR_STRENGTH_THRESH:  st_next.rdata = st_reg.thresh;
                ADDR_RX_START_TO:      st_next.rdata = st_reg.to_start;
                ADDR_POST_STRENGTH_TO: st_next.rdata = st_reg.to_post;
                default:               st_next.rdata = 8'h00;
            endcase
        end
    end

    // ==========================================================================
    // State register with documented reset values.
    always_ff @(posedge clock or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            st_reg            <= '0;
            st_reg.route      <= {6{RST_ROUTE_SEL}};
            st_reg.clk_sel    <= RST_CLK_SEL;
            st_reg.thresh     <= RST_THRESHOLD;
            st_reg.to_start   <= RST_TIMEOUT;
            st_reg.to_post    <= RST_TIMEOUT;
            st_reg.flags_mode <= {RST_MODE_REACHED, 7'h00};
            st_reg.pins       <= 6'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================================
    // Outputs; the clock pin passes the reference straight through for code 0.
    assign rdata        = st_reg.rdata;
    assign pins         = st_reg.pins;
    assign buffer_flush = st_reg.flush;
    assign rx_restart   = st_reg.restart;
    assign rc_enable    = (st_reg.clk_sel == CLK_SEL_RC);
    assign clock_pin    = (st_reg.clk_sel == 3'h0) ? clock :
                          (st_reg.clk_sel == CLK_SEL_RC) ? rc_clock : st_reg.div_out;

    // ==========================================================================
    // Checks on the flag behaviour.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n_sync);

    chk_route_pin_agree: assert property (
        pins[0] == route_event(st_reg.route[0], st_reg.flags_mode, st_reg.flags_buf))
        else $error("pin 0 disagrees with its routed flag");

    chk_mode_change_clear: assert property (
        (mode != $past(mode) && !mode_done) |=> !st_reg.flags_mode[BIT_MODE_REACHED])
        else $error("mode reached flag not cleared on mode change");

    chk_rx_settled_exit: assert property (
        !in_rx |=> !st_reg.flags_mode[BIT_RX_SETTLED])
        else $error("receive settled flag outside receive");

    chk_lock_follow: assert property (
        (synth_lock && in_tx) |=> st_reg.flags_mode[BIT_SYNTH_LOCKED])
        else $error("lock flag did not follow lock");

    chk_strength_set: assert property (
        strength_hit |=> st_reg.flags_mode[BIT_STRENGTH])
        else $error("strength flag not set");

    chk_full_exact: assert property (
        (buffer_count == DEPTH_W'(BUFFER_DEPTH)) |=> st_reg.flags_buf[BIT_BUF_FULL])
        else $error("full flag missing at full count");

    chk_level_strict: assert property (
        (buffer_count == buffer_level_threshold) |=> !st_reg.flags_buf[BIT_BUF_LEVEL])
        else $error("level flag set at equal count");

    chk_overflow_flush: assert property (
        (wr && addr == ADDR_FLAGS_BUFFER && wdata[BIT_BUF_OVERFLOW]) |=> buffer_flush)
        else $error("overflow clear did not flush");

    chk_sleep_no_ovf: assert property (
        (mode == MODE_SLEEP && !st_reg.flags_buf[BIT_BUF_OVERFLOW])
            |=> !st_reg.flags_buf[BIT_BUF_OVERFLOW])
        else $error("overflow flag set in sleep");

    chk_bad_crc_restart: assert property (
        frame_bad |=> (rx_restart && buffer_flush && !st_reg.flags_buf[BIT_RX_COMPLETE]))
        else $error("bad frame not restarted");

    chk_start_timeout: assert property (
        t1_fire |=> st_reg.flags_mode[BIT_TIMEOUT] && !st_reg.t1_run)
        else $error("start timeout did not raise flag");

    cov_timeout_fire:  cover property (t1_fire || t2_fire);
    cov_frame_ok:      cover property (frame_ok ##1 st_reg.flags_buf[BIT_RX_COMPLETE]);
    cov_overflow_wipe: cover property (st_reg.flags_buf[BIT_BUF_OVERFLOW] ##1 ovf_clear);
    cov_full_buffer:   cover property (st_reg.flags_buf[BIT_BUF_FULL]);

endmodule : radio_irq_flags_pin_map

// *** verification/radio_host_model.sv ***
// Host model: register bus master of the flag unit.
`timescale 1ns/1ps
module radio_host_model (
    input  wire logic       clock,
    input  wire logic [7:0] rdata,
    output logic      [7:0] addr,
    output logic      [7:0] wdata,
    output logic            wr,
    output logic            rd
);
    // ========================================================================
    // The bus starts idle.
    initial {addr, wdata, wr, rd} = 18'h0;
    // One-cycle write.
    task automatic wr_reg(input logic [7:0] a, dv);
        @(posedge clock);
        addr  <= a;
        wdata <= dv;
        wr    <= 1'h1;
        @(posedge clock);
        wr    <= 1'h0;
        wdata <= ~dv;
    endtask : wr_reg
    // One-cycle read; data is taken the cycle after the strobe.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] dv);
        @(posedge clock);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clock);
        rd   <= 1'h0;
        #1;
        dv = rdata;
    endtask : rd_reg
endmodule : radio_host_model

// *** verification/tb_radio_irq_flags_pin_map.sv ***
// Self-checking bench of the flag unit: registers, flags, pins and timeouts.
`timescale 1ns/1ps
module tb_radio_irq_flags_pin_map;
    import radio_irq_pkg::*;
    // ========================================================================
    // Inputs start at rest.
    logic       clock = 1'h0, rstn = 1'h0, mode_done = 1'h0, rx_settled = 1'h0;
    logic       tx_ramped = 1'h0, synth_lock = 1'h0, strength_valid = 1'h0, sync_found = 1'h0;
    logic       intermediate_mode = 1'h0, buffer_overrun = 1'h0, frame_done = 1'h0;
    logic       continuous_mode = 1'h0;
    logic       last_byte = 1'h0, crc_on = 1'h0, crc_pass = 1'h0, keep_bad_frame = 1'h0;
    logic       bit_tick = 1'h0, wr, rd, clock_pin, rc_enable, buffer_flush, rx_restart, prev;
    logic [2:0] mode = MODE_SLEEP;
    logic [5:0] pins;
    logic [6:0] buffer_count = 7'h00, buffer_level_threshold = 7'h00, c, t;
    logic [7:0] addr, wdata, rdata, d, e, measured_strength = 8'h00;
    logic [31:0] seed = 32'h0000f9e8;
    int         num_errors = 0, checks = 0, cycles = 0, n;
    logic [7:0] rst_val [8] = '{8'h00, 8'h07, 8'h80, 8'h00, 8'he4, 8'h00, 8'h00, 8'h00};
    logic [7:0] wa [5] = '{8'h25, 8'h26, 8'h29, 8'h2a, 8'h2b};
    logic [7:0] wm [5] = '{8'hff, 8'hf7, 8'hff, 8'hff, 8'hff};
    logic [6:0] cc [3] = '{7'h42, 7'h41, 7'h00};

    radio_host_model u_host (.clock, .rdata, .addr, .wdata, .wr, .rd);
    // The RC clock stand-in is the released reset, high during the tests.
    radio_irq_flags_pin_map u_dut (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata, .mode,
        .mode_done, .rx_settled, .tx_ramped, .synth_lock, .strength_valid, .measured_strength,
        .intermediate_mode, .sync_found, .continuous_mode, .buffer_count,
        .buffer_level_threshold, .buffer_overrun, .frame_done, .last_byte, .crc_on, .crc_pass,
        .keep_bad_frame, .bit_tick, .rc_clock(rstn), .pins, .clock_pin, .rc_enable,
        .buffer_flush, .rx_restart);

    // Clock and cycle ceiling.
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // Xorshift random source.
    function automatic logic [7:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : next_rand
    // Expected full, nonempty and level flag bits.
    function automatic logic [7:0] exp_buf(input logic [6:0] cnt, thr);
        return {cnt == 7'(BUFFER_DEPTH), cnt != 7'h00, cnt > thr, 5'h00};
    endfunction : exp_buf
    // Compare, and masked register read.
    task automatic check(input string s, input logic [7:0] x, g);
        checks++;
        if (g !== x) begin
            num_errors++;
            $display("Error %s expected %h seen %h", s, x, g);
        end
    endtask : check
    task automatic rchk(input string s, input logic [7:0] a, x, m);
        u_host.rd_reg(a, d);
        check(s, x, d & m);
    endtask : rchk
    // Bit ticks, then the timeout flag.
    task automatic tick_chk(input int k, input logic [7:0] x);
        repeat (k) begin
            bit_tick <= 1'h1;
            @(posedge clock);
            bit_tick <= 1'h0;
            @(posedge clock);
        end
        rchk("timeout flag", ADDR_FLAGS_MODE, x, 8'h04);
    endtask : tick_chk
    // Last byte with a checksum outcome.
    task automatic frame(input logic p, k, input logic [7:0] x);
        crc_pass <= p;
        keep_bad_frame <= k;
        last_byte <= 1'h1;
        @(posedge clock);
        last_byte <= 1'h0;
        #1;
        check("restart", {7'h0, ~(p | k)}, {7'h0, rx_restart});
        rchk("frame flags", ADDR_FLAGS_BUFFER, x, 8'h06);
    endtask : frame
    // Final counts and verdict.
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence of tests.
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'h1;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            rchk("reset", 8'h25 + 8'(i), rst_val[i], 8'hff);
        end
        for (int i = 0; i < 10; i++) begin
            c = (i < 3) ? cc[i] : 7'(next_rand() % 8'h43);
            t = (i < 3) ? 7'h41 : 7'(next_rand());
            e = exp_buf(c, t);
            buffer_count <= c;
            buffer_level_threshold <= t;
            rchk("buffer flags", ADDR_FLAGS_BUFFER, e, 8'he0);
            check("pins", {2'h0, {6{e[BIT_BUF_LEVEL]}}}, {2'h0, pins});
        end
        $display("test buffer flags done");
        for (int i = 0; i < 5; i++) begin
            e = next_rand();
            u_host.wr_reg(wa[i], e);
            rchk("readback", wa[i], e & wm[i], 8'hff);
        end
        buffer_count <= 7'h01;
        buffer_level_threshold <= 7'h02;
        for (int i = 0; i < 4; i++) begin
            u_host.wr_reg(ADDR_PIN_ROUTE_LOW, {4{2'(i)}});
            u_host.wr_reg(ADDR_PIN_ROUTE_HIGH, {2'(i), 2'(i), 4'h6});
            repeat (3) @(posedge clock);
            #1;
            check("routed pins", {2'h3, {6{i[0]}}},
                  {clock_pin, rc_enable, pins});
        end
        u_host.wr_reg(ADDR_PIN_ROUTE_HIGH, 8'h05);
        repeat (4) @(posedge clock);
        #1;
        prev = clock_pin;
        n = 0;
        repeat (64) begin
            @(posedge clock);
            #1;
            if (clock_pin !== prev) n++;
            prev = clock_pin;
        end
        check("divide by 32 toggles", 8'h04, 8'(n));
        $display("test routing done");
        u_host.wr_reg(ADDR_STRENGTH_THRESH, 8'h40);
        mode <= MODE_RX;
        rchk("mode change", ADDR_FLAGS_MODE, 8'h00, 8'h80);
        {mode_done, rx_settled, sync_found, strength_valid} <= 4'hf;
        measured_strength <= 8'h40;
        @(posedge clock);
        {mode_done, rx_settled, sync_found, strength_valid} <= 4'h0;
        rchk("rx flags", ADDR_FLAGS_MODE, 8'hc1, 8'hff);
        strength_valid <= 1'h1;
        measured_strength <= 8'h41;
        @(posedge clock);
        strength_valid <= 1'h0;
        rchk("strength", ADDR_FLAGS_MODE, 8'hc9, 8'hff);
        u_host.wr_reg(ADDR_FLAGS_MODE, 8'h09);
        rchk("strength clear", ADDR_FLAGS_MODE, 8'hc1, 8'hff);
        buffer_count <= 7'h00;
        rchk("sync clear", ADDR_FLAGS_MODE, 8'hc0, 8'hff);
        {continuous_mode, sync_found} <= 2'h3;
        @(posedge clock);
        sync_found <= 1'h0;
        u_host.wr_reg(ADDR_FLAGS_MODE, 8'h01);
        rchk("sync write clear", ADDR_FLAGS_MODE, 8'hc0, 8'hff);
        mode <= MODE_STANDBY;
        rchk("rx left", ADDR_FLAGS_MODE, 8'h00, 8'hff);
        u_host.wr_reg(ADDR_RX_START_TO, 8'h01);
        u_host.wr_reg(ADDR_POST_STRENGTH_TO, 8'h00);
        mode <= MODE_RX;
        @(posedge clock);
        tick_chk(15, 8'h00);
        tick_chk(1, 8'h04);
        mode <= MODE_STANDBY;
        rchk("timeout clear", ADDR_FLAGS_MODE, 8'h00, 8'h04);
        u_host.wr_reg(ADDR_RX_START_TO, 8'h00);
        u_host.wr_reg(ADDR_POST_STRENGTH_TO, 8'h01);
        mode <= MODE_RX;
        @(posedge clock);
        strength_valid <= 1'h1;
        @(posedge clock);
        strength_valid <= 1'h0;
        tick_chk(15, 8'h00);
        tick_chk(1, 8'h04);
        $display("test receive done");
        crc_on <= 1'h1;
        buffer_count <= 7'h03;
        frame(1'h0, 1'h0, 8'h00);
        frame(1'h1, 1'h0, 8'h06);
        buffer_count <= 7'h00;
        rchk("emptied", ADDR_FLAGS_BUFFER, 8'h00, 8'h06);
        buffer_count <= 7'h03;
        frame(1'h0, 1'h1, 8'h04);
        mode <= MODE_SLEEP;
        buffer_overrun <= 1'h1;
        @(posedge clock);
        buffer_overrun <= 1'h0;
        rchk("overrun sleep", ADDR_FLAGS_BUFFER, 8'h00, 8'h10);
        mode <= MODE_STANDBY;
        buffer_overrun <= 1'h1;
        @(posedge clock);
        buffer_overrun <= 1'h0;
        rchk("overrun", ADDR_FLAGS_BUFFER, 8'h10, 8'h10);
        u_host.wr_reg(ADDR_FLAGS_BUFFER, 8'h10);
        #1;
        check("flush", 8'h01, {7'h0, buffer_flush});
        rchk("overrun clear", ADDR_FLAGS_BUFFER, 8'h00, 8'h16);
        {synth_lock, intermediate_mode, tx_ramped} <= 3'h7;
        mode <= MODE_TX;
        @(posedge clock);
        frame_done <= 1'h1;
        @(posedge clock);
        frame_done <= 1'h0;
        rchk("tx flags", ADDR_FLAGS_MODE, 8'h32, 8'h32);
        rchk("sent", ADDR_FLAGS_BUFFER, 8'h08, 8'h08);
        intermediate_mode <= 1'h0;
        mode <= MODE_SYNTH;
        rchk("tx left", ADDR_FLAGS_MODE, 8'h10, 8'h32);
        rchk("sent clear", ADDR_FLAGS_BUFFER, 8'h00, 8'h08);
        $display("test frames done");
        tally_and_finish();
    end
endmodule : tb_radio_irq_flags_pin_map
